// ### common/ring_drive_pkg.sv
// types shared by the ring drive synth
package ring_drive_pkg;

	// offset between sampling and primary rates
	typedef enum logic {
		RING_ALIAS,
		ZERO_OFFSET
	} mode_e;

	// pin inputs that cross into the clock domain together
	typedef struct packed {
		logic refClock;
		logic selHi;
		logic selLo;
		logic enable;
		logic overcurrent;
		logic offHookSense;
	} pins_s;

	// interrupt events, one bit each
	typedef struct packed {
		logic hookOn;
		logic hookOff;
		logic limit;
	} irq_s;

endpackage

// ### common/ring_drive_regs.svh
// register offsets, field positions, reset values and timing figures of the ring drive synth
`ifndef RING_DRIVE_REGS_SVH
`define RING_DRIVE_REGS_SVH

// byte offsets on the register bus
`define RD_ADDR_W 5
`define RD_OFF_CTRL 5'h00
`define RD_OFF_STATUS 5'h04
`define RD_OFF_IRQ_STATUS 5'h08
`define RD_OFF_IRQ_CLEAR 5'h0C
`define RD_OFF_IRQ_ENABLE 5'h10

// control register fields
`define RD_CTRL_SOFT_EN 0
`define RD_CTRL_RESET 1'h1

// status register fields
`define RD_ST_OFFHOOK 0
`define RD_ST_LIMIT 1
`define RD_ST_ENABLED 2
`define RD_ST_SEL_LO 3
`define RD_ST_SEL_HI 4
`define RD_ST_ZERO_OFFSET 5

// interrupt fields, shared by status, clear and enable
`define RD_IRQ_W 3
`define RD_IRQ_LIMIT 0
`define RD_IRQ_HOOK_OFF 1
`define RD_IRQ_HOOK_ON 2
`define RD_IRQ_RESET 3'h0

// reference and rates, in hertz, and the primary divider
`define RD_REF_HZ 3579545
`define RD_SAMPLE_HZ_20 89469
`define RD_SAMPLE_HZ_25 89464
`define RD_SAMPLE_HZ_50 89439
`define RD_PRIMARY_DIV 40

// sampling pulse width and the system clock
`define RD_SAMPLE_WIDTH_NS 280
`define RD_CLK_MHZ 100
`define RD_NS_PER_US 1000

`define RD_ACC_W 24
`define RD_DATA_ZERO 32'h0000_0000

`endif

// ### logic/ring_drive_frequency_synth.sv
// ring drive timing: crystal-derived primary and sampling drives with an Avalon-MM register file
`timescale 1ns/1ps
`include "ring_drive_regs.svh"

// Contract
// - primary and sampling rates both come from the 3579545 Hz crystal reference
// - primary outputs toggle at 89.489 kHz whatever the select inputs say
// - sampling rate sits 20, 25 or 50 Hz below primary, or equal to it, set by selects
// - both selects low: mode 0, sampling at 89469 Hz, 20 Hz ring
// - low select high only: sampling at 89464 Hz, 25 Hz ring
// - high select high only: sampling at 89439 Hz, 50 Hz ring
// - both selects high: mode 3, zero offset, no ring alias
// - off-hook flag high while sensed secondary current is over its limit
// - every sampling pulse lasts 280 ns
// - the two primary drives are complementary, 50 percent duty each
// - all drives inactive while the enable input is low
// - overcurrent trip blanks all drives for the rest of this switching cycle
module ring_drive_frequency_synth #(
	parameter int ACC_W = `RD_ACC_W,
	parameter int PRIMARY_DIV = `RD_PRIMARY_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [`RD_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic irq,
	input wire logic refClockIn,
	input wire logic ringRateSelectLo,
	input wire logic ringRateSelectHi,
	input wire logic driveEnableIn,
	input wire logic primaryOvercurrentIn,
	input wire logic offHookSenseIn,
	output logic primaryDriveA,
	output logic primaryDriveB,
	output logic samplePulseDrive,
	output logic offHookFlag
);

	// pulse width rounded up to whole clocks, so it never comes out short
	// a different system clock only needs the clock figure changed
	localparam int SAMPLE_CYC =
		(`RD_SAMPLE_WIDTH_NS * `RD_CLK_MHZ + `RD_NS_PER_US - 1) / `RD_NS_PER_US;
	localparam int PRIM_W = $clog2(PRIMARY_DIV);
	localparam logic [PRIM_W-1:0] PRIM_LAST = PRIM_W'(PRIMARY_DIV - 1);
	localparam logic [PRIM_W-1:0] PRIM_HALF = PRIM_W'(PRIMARY_DIV / 2);
	localparam logic [7:0] SAMPLE_LOAD = 8'(SAMPLE_CYC);

	// refuse sizes that the counters or the step arithmetic cannot hold
	initial
	begin
		if (ACC_W < 16 || ACC_W > 32)
			$error("accumulator width must lie between 16 and 32");
		if (PRIMARY_DIV < 4 || (PRIMARY_DIV % 2) != 0)
			$error("primary divider must be even and at least 4");
		if (SAMPLE_CYC < 1 || SAMPLE_CYC > 255)
			$error("sample pulse count out of range");
	end

	// phase step per reference tick for a wanted rate, rounded to nearest
	// 64-bit intermediate keeps the shifted rate from overflowing at 32 bits
	function automatic logic [ACC_W-1:0] rateStep(input logic [31:0] hz);
		logic [63:0] num;
		num = ({32'h0000_0000, hz} << ACC_W) + 64'(`RD_REF_HZ / 2);
		rateStep = ACC_W'(num / 64'(`RD_REF_HZ));
	endfunction

	// pin synchronisers
	// all pins share one two-flop chain, so they stay aligned to each other
	// the crystal is sampled as a pin: its edges jitter by one clock,
	// which averages out over a switching cycle
	ring_drive_pkg::pins_s pinsRaw;
	ring_drive_pkg::pins_s pinsMeta;
	ring_drive_pkg::pins_s pins;
	logic refPrev;

	assign pinsRaw = '{refClock: refClockIn, selHi: ringRateSelectHi,
		selLo: ringRateSelectLo, enable: driveEnableIn,
		overcurrent: primaryOvercurrentIn, offHookSense: offHookSenseIn};

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pinsMeta <= '0;
			pins <= '0;
			refPrev <= 1'b0;
		end
		else if (clkEn)
		begin
			pinsMeta <= pinsRaw;
			pins <= pinsMeta;
			refPrev <= pins.refClock;
		end
	end

	logic refTick;
	assign refTick = pins.refClock & ~refPrev;

	ring_drive_pkg::mode_e mode;
	assign mode = (pins.selHi && pins.selLo) ? ring_drive_pkg::ZERO_OFFSET
		: ring_drive_pkg::RING_ALIAS;

	// selects are hard-wired in use; a live change only shifts the phase
	logic [ACC_W-1:0] step;
	always_comb
	begin
		if (!pins.selHi && !pins.selLo)
			step = rateStep(32'(`RD_SAMPLE_HZ_20));
		else if (!pins.selHi)
			step = rateStep(32'(`RD_SAMPLE_HZ_25));
		else
			step = rateStep(32'(`RD_SAMPLE_HZ_50));
	end

	// register state
	// soft enable resets high so the pins alone can run the drives
	logic softEnable;
	ring_drive_pkg::irq_s irqStatus;
	ring_drive_pkg::irq_s irqEnable;
	logic ack;

	// drive timing
	// drives are registered so the power stage never sees decode glitches
	// hookPrev loads the same value as the flag, so the edge events compare the flag with its next value
	logic [PRIM_W-1:0] primCnt;
	logic [ACC_W-1:0] phaseAcc;
	logic [7:0] pulseCnt;
	logic limitBlank;
	logic hookPrev;
	logic next_primaryDriveA;
	logic next_primaryDriveB;
	logic next_samplePulseDrive;
	logic next_offHookFlag;
	logic [PRIM_W-1:0] next_primCnt;
	logic [ACC_W-1:0] next_phaseAcc;
	logic [7:0] next_pulseCnt;
	logic next_limitBlank;
	logic driveEnabled;
	logic cycleStart;
	logic sampleStart;
	logic [ACC_W:0] accSum;
	logic driveGate;

	assign driveEnabled = pins.enable & softEnable;

	always_comb
	begin
		next_primCnt = primCnt;
		next_phaseAcc = phaseAcc;
		accSum = {1'b0, phaseAcc} + {1'b0, step};
		cycleStart = refTick && (primCnt == PRIM_LAST);
		if (refTick)
		begin
			// divide by 40 gives 89.489 kHz regardless of selects
			next_primCnt = cycleStart ? '0 : primCnt + 1'b1;
			next_phaseAcc = accSum[ACC_W-1:0];
		end
		if (mode == ring_drive_pkg::ZERO_OFFSET)
			sampleStart = cycleStart;
		else
			sampleStart = refTick && accSum[ACC_W];

		// blank held to end of cycle; a trip at the boundary still wins
		if (pins.overcurrent)
			next_limitBlank = 1'b1;
		else if (cycleStart)
			next_limitBlank = 1'b0;
		else
			next_limitBlank = limitBlank;

		if (sampleStart)
			next_pulseCnt = SAMPLE_LOAD;
		else if (pulseCnt != 8'h00)
			next_pulseCnt = pulseCnt - 8'h01;
		else
			next_pulseCnt = pulseCnt;

		driveGate = driveEnabled && !next_limitBlank;
		next_primaryDriveA = driveGate && (next_primCnt < PRIM_HALF);
		next_primaryDriveB = driveGate && !(next_primCnt < PRIM_HALF);
		next_samplePulseDrive = driveGate && (next_pulseCnt != 8'h00);
		next_offHookFlag = pins.offHookSense;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			primCnt <= '0;
			phaseAcc <= '0;
			pulseCnt <= 8'h00;
			limitBlank <= 1'b0;
			hookPrev <= 1'b0;
			primaryDriveA <= 1'b0;
			primaryDriveB <= 1'b0;
			samplePulseDrive <= 1'b0;
			offHookFlag <= 1'b0;
		end
		else if (clkEn)
		begin
			primCnt <= next_primCnt;
			phaseAcc <= next_phaseAcc;
			pulseCnt <= next_pulseCnt;
			limitBlank <= next_limitBlank;
			hookPrev <= next_offHookFlag;
			primaryDriveA <= next_primaryDriveA;
			primaryDriveB <= next_primaryDriveB;
			samplePulseDrive <= next_samplePulseDrive;
			offHookFlag <= next_offHookFlag;
		end
	end

	// Avalon-MM slave
	// a fixed single wait cycle trades speed for registered read data
	// one wait cycle per access: read data is ready when waitrequest drops
	logic next_ack;
	logic [31:0] next_readdata;
	logic next_softEnable;
	ring_drive_pkg::irq_s next_irqStatus;
	ring_drive_pkg::irq_s next_irqEnable;
	ring_drive_pkg::irq_s events;
	logic writeNow;
	logic [31:0] statusWord;

	assign waitrequest = (read | write) & ~ack;
	assign writeNow = write & ack & byteenable[0];
	assign irq = |(irqStatus & irqEnable);

	always_comb
	begin
		statusWord = `RD_DATA_ZERO;
		statusWord[`RD_ST_OFFHOOK] = offHookFlag;
		statusWord[`RD_ST_LIMIT] = limitBlank;
		statusWord[`RD_ST_ENABLED] = driveEnabled;
		statusWord[`RD_ST_SEL_LO] = pins.selLo;
		statusWord[`RD_ST_SEL_HI] = pins.selHi;
		statusWord[`RD_ST_ZERO_OFFSET] = (mode == ring_drive_pkg::ZERO_OFFSET);

		events.limit = next_limitBlank & ~limitBlank;
		events.hookOff = next_offHookFlag & ~hookPrev;
		events.hookOn = ~next_offHookFlag & hookPrev;

		next_ack = (read | write) & ~ack;
		next_readdata = readdata;
		if (read && !ack)
		begin
			if (address == `RD_OFF_CTRL)
				next_readdata = {31'h0000_0000, softEnable};
			else if (address == `RD_OFF_STATUS)
				next_readdata = statusWord;
			else if (address == `RD_OFF_IRQ_STATUS)
				next_readdata = {29'h0000_0000, irqStatus};
			else if (address == `RD_OFF_IRQ_ENABLE)
				next_readdata = {29'h0000_0000, irqEnable};
			else
				next_readdata = `RD_DATA_ZERO;
		end

		next_softEnable = softEnable;
		next_irqEnable = irqEnable;
		next_irqStatus = irqStatus;
		if (writeNow)
		begin
			if (address == `RD_OFF_CTRL)
				next_softEnable = writedata[`RD_CTRL_SOFT_EN];
			else if (address == `RD_OFF_IRQ_CLEAR)
				next_irqStatus = irqStatus & ~writedata[`RD_IRQ_W-1:0];
			else if (address == `RD_OFF_IRQ_ENABLE)
				next_irqEnable = writedata[`RD_IRQ_W-1:0];
		end
		// a new event outranks a clear in the same cycle
		next_irqStatus = next_irqStatus | events;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack <= 1'b0;
			readdata <= `RD_DATA_ZERO;
			softEnable <= `RD_CTRL_RESET;
			irqStatus <= `RD_IRQ_RESET;
			irqEnable <= `RD_IRQ_RESET;
		end
		else if (clkEn)
		begin
			ack <= next_ack;
			readdata <= next_readdata;
			softEnable <= next_softEnable;
			irqStatus <= next_irqStatus;
			irqEnable <= next_irqEnable;
		end
	end

endmodule // ring_drive_frequency_synth

// ### sim/ring_drive_frequency_synth_sva.sv
// pin-level checks on the ring drive synth
`timescale 1ns/1ps
module ring_drive_frequency_synth_chk #(
	parameter int ACC_W = 24,
	parameter int PRIMARY_DIV = 40
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic waitrequest,
	input wire logic refClockIn,
	input wire logic ringRateSelectLo,
	input wire logic ringRateSelectHi,
	input wire logic driveEnableIn,
	input wire logic primaryOvercurrentIn,
	input wire logic offHookSenseIn,
	input wire logic primaryDriveA,
	input wire logic primaryDriveB,
	input wire logic samplePulseDrive,
	input wire logic offHookFlag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	int quiet, wid, ticks;
	logic runClean, off;
	assign off = !(primaryDriveA || primaryDriveB || samplePulseDrive);
	// quiet outlasts a primary period, so cut pulses and halves are never judged
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			quiet <= 500;
			wid <= 0;
			ticks <= 0;
			runClean <= 1'b0;
		end
		else
		begin
			if (!driveEnableIn || primaryOvercurrentIn || $changed({ringRateSelectLo, ringRateSelectHi}))
				quiet <= 500;
			else if (quiet > 0)
				quiet <= quiet - 1;
			wid <= samplePulseDrive ? wid + 1 : 0;
			ticks <= primaryDriveA ? ticks + int'($rose(refClockIn)) : 0;
			if ($rose(primaryDriveA))
				runClean <= quiet == 0;
		end
	end
	chk_drive_overlap: assert property (!(primaryDriveA && primaryDriveB))
		else $error("primary drives overlap");
	chk_enable_gate: assert property (!driveEnableIn [*5] |=> off)
		else $error("drives on while disabled");
	chk_limit_gate: assert property (primaryOvercurrentIn [*5] |=> off)
		else $error("drives on during overcurrent");
	chk_pulse_width: assert property ($fell(samplePulseDrive) && quiet == 0 |-> wid == 28)
		else $error("sample pulse width wrong");
	chk_half_period: assert property ($fell(primaryDriveA) && runClean && quiet == 0
		|-> ticks == PRIMARY_DIV / 2) else $error("primary half period wrong");
	chk_zero_offset: assert property ($rose(primaryDriveA) && ringRateSelectLo
		&& ringRateSelectHi && quiet == 0 |-> ##[0:2] samplePulseDrive)
		else $error("sample not at cycle start");
	chk_offhook_flag: assert property (offHookSenseIn [*5] |=> offHookFlag)
		else $error("off-hook flag missing");
	chk_wait_once: assert property (waitrequest |=> !waitrequest)
		else $error("more than one wait cycle");
	cover property ($fell(samplePulseDrive) && wid == 28);
	cover property (primaryOvercurrentIn [*5]);
	cover property (waitrequest ##1 !waitrequest);
endmodule // ring_drive_frequency_synth_chk

bind ring_drive_frequency_synth ring_drive_frequency_synth_chk #(.ACC_W(ACC_W),
	.PRIMARY_DIV(PRIMARY_DIV)) ring_drive_frequency_synth_chk_i (.clk, .rst_n, .waitrequest,
	.refClockIn, .ringRateSelectLo, .ringRateSelectHi, .driveEnableIn, .primaryOvercurrentIn,
	.offHookSenseIn, .primaryDriveA, .primaryDriveB, .samplePulseDrive, .offHookFlag);

// ### sim/ring_drive_frequency_synth_tb.sv
// self-checking bench for the ring drive synth
`timescale 1ns/1ps
`include "ring_drive_regs.svh"
module ring_drive_frequency_synth_tb;
	logic clk, rst_n, read, write, waitrequest, irq, refClockIn, clearCounts, tripReq, loadReq;
	logic ringRateSelectLo, ringRateSelectHi, driveEnableIn, primaryOvercurrentIn;
	logic offHookSenseIn, primaryDriveA, primaryDriveB, samplePulseDrive, offHookFlag;
	logic [4:0] address;
	logic [31:0] writedata, readdata, q;
	int failCount, checkCount, primaryCount, sampleCount, d;
	ring_drive_frequency_synth ring_drive_frequency_synth_i (.clk, .rst_n, .clkEn(1'b1),
		.address, .read, .write, .writedata, .byteenable(4'hf), .readdata, .waitrequest, .irq,
		.refClockIn, .ringRateSelectLo, .ringRateSelectHi, .driveEnableIn,
		.primaryOvercurrentIn, .offHookSenseIn, .primaryDriveA, .primaryDriveB,
		.samplePulseDrive, .offHookFlag);
	ring_drive_stage_model ring_drive_stage_model_i (.clk, .primaryDriveA, .samplePulseDrive,
		.clearCounts, .tripReq, .loadReq, .overcurrent(primaryOvercurrentIn),
		.offHookSense(offHookSenseIn), .primaryCount, .sampleCount);
	task check(input logic [31:0] got, input logic [31:0] exp, input string m);
		checkCount++;
		if (got !== exp)
		begin
			failCount++;
			$display("wrong value at %0t: %s got %h", $time, m, got);
		end
	endtask
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		address <= a;
		writedata <= dat;
		write <= wr;
		read <= !wr;
		do
		begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0)
		begin
			failCount++;
			$display("wrong value at %0t: bus wait timeout", $time);
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check(q, exp, "read");
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	initial
	begin
		refClockIn = 1'b0;
		// slow reference keeps each tick clear of the sync delay
		forever
		begin
			repeat (5) @(posedge clk);
			refClockIn <= !refClockIn;
		end
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		failCount++;
		$display("wrong value at %0t: timeout", $time);
		conclude;
	end
	initial
	begin
		{rst_n, read, write, address, writedata, clearCounts, tripReq, loadReq} = '0;
		{ringRateSelectLo, ringRateSelectHi} = 2'b00;
		driveEnableIn = 1'b1;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`RD_OFF_CTRL, 32'h0000_0001);
		rd(`RD_OFF_IRQ_ENABLE, 32'h0000_0000);
		bus(1'b1, 5'h14, 32'hFFFF_FFFF);
		rd(5'h14, 32'h0000_0000);
		$display("registers done");
		for (int m = 0; m < 4; m++)
		begin
			{ringRateSelectHi, ringRateSelectLo} <= 2'(m);
			repeat (600) @(posedge clk);
			clearCounts <= 1'b1;
			@(posedge clk);
			clearCounts <= 1'b0;
			repeat (8000) @(posedge clk);
			check(32'(primaryCount), 32'h0000_0014, "primary");
			d = sampleCount - primaryCount;
			check({31'h0, d >= -1 && d <= 1}, 32'h0000_0001, "sample");
			rd(`RD_OFF_STATUS, {26'h0, m == 3, 2'(m), 3'h4});
			$display("mode %0d done", m);
		end
		bus(1'b1, `RD_OFF_IRQ_ENABLE, 32'h0000_0000);
		loadReq <= 1'b1;
		repeat (10) @(posedge clk);
		check(offHookFlag, 1, "offhook");
		check(irq, 0, "masked");
		rd(`RD_OFF_IRQ_STATUS, 32'h0000_0002);
		bus(1'b1, `RD_OFF_IRQ_ENABLE, 32'h0000_0003);
		check(irq, 1, "irq");
		bus(1'b1, `RD_OFF_IRQ_CLEAR, 32'h0000_0002);
		check(irq, 0, "cleared");
		loadReq <= 1'b0;
		repeat (10) @(posedge clk);
		check(offHookFlag, 0, "onhook");
		rd(`RD_OFF_IRQ_STATUS, 32'h0000_0004);
		$display("off-hook done");
		tripReq <= 1'b1;
		repeat (12) @(posedge clk);
		#1 check({primaryDriveA, primaryDriveB, samplePulseDrive}, 0, "blank");
		check(irq, 1, "limit irq");
		@(posedge clk);
		tripReq <= 1'b0;
		bus(1'b1, `RD_OFF_IRQ_CLEAR, 32'h0000_0007);
		check(irq, 0, "limit clear");
		repeat (450) @(posedge clk);
		#1 check(primaryDriveA ^ primaryDriveB, 1, "resume");
		@(posedge clk);
		driveEnableIn <= 1'b0;
		repeat (6) @(posedge clk);
		#1 check({primaryDriveA, primaryDriveB, samplePulseDrive}, 0, "pin off");
		@(posedge clk);
		driveEnableIn <= 1'b1;
		bus(1'b1, `RD_OFF_CTRL, 32'h0000_0000);
		#1 check({primaryDriveA, primaryDriveB, samplePulseDrive}, 0, "soft off");
		@(posedge clk);
		rd(`RD_OFF_CTRL, 32'h0000_0000);
		bus(1'b1, `RD_OFF_CTRL, 32'h0000_0001);
		repeat (450) @(posedge clk);
		#1 check(primaryDriveA ^ primaryDriveB, 1, "back on");
		$display("gating done");
		conclude;
	end
endmodule // ring_drive_frequency_synth_tb

// ### sim/ring_drive_stage_model.sv
// power stage stand-in: counts drive edges, raises commanded faults
`timescale 1ns/1ps
module ring_drive_stage_model (
	input wire logic clk,
	input wire logic primaryDriveA,
	input wire logic samplePulseDrive,
	input wire logic clearCounts,
	input wire logic tripReq,
	input wire logic loadReq,
	output logic overcurrent,
	output logic offHookSense,
	output int primaryCount,
	output int sampleCount
);
	logic lastA = 1'b0;
	logic lastS = 1'b0;
	initial
	begin
		overcurrent = 1'b0;
		offHookSense = 1'b0;
	end
	always @(posedge clk)
	begin
		lastA <= primaryDriveA;
		lastS <= samplePulseDrive;
		primaryCount <= clearCounts ? 0 : primaryCount + int'(primaryDriveA && !lastA);
		sampleCount <= clearCounts ? 0 : sampleCount + int'(samplePulseDrive && !lastS);
		overcurrent <= tripReq;
		offHookSense <= loadReq;
	end
endmodule // ring_drive_stage_model
